// *** rtl/lcr_pkg.sv ***
package lcr_pkg;

   // Map geometry
   localparam int           NUM_CHAN      = 14;
   localparam logic [3:0]   CHAN_LAST     = 4'hd;
   localparam logic [3:0]   CHAN_REG0     = 4'h0;
   localparam logic [3:0]   CHAN_REG1     = 4'h1;

   // Global register offsets
   localparam logic [7:0]   ADR_CLK_DATA  = 8'he0;
   localparam logic [7:0]   ADR_GAUGE     = 8'he1;
   localparam logic [7:0]   ADR_EQ_FLAG   = 8'he2;
   localparam logic [7:0]   ADR_SLICER    = 8'he3;
   localparam logic [7:0]   ADR_MCLK_OUT  = 8'he4;
   localparam logic [7:0]   ADR_ERR_SEL   = 8'he5;
   localparam logic [7:0]   ADR_CNT_UPD   = 8'he6;
   localparam logic [7:0]   ADR_SPARE     = 8'he7;
   localparam logic [7:0]   ADR_ERR_CNT   = 8'he8;
   localparam logic [7:0]   ADR_CLK_SRC   = 8'he9;
   localparam logic [7:0]   ADR_IRQ_LO    = 8'hea;
   localparam logic [7:0]   ADR_IRQ_HI    = 8'heb;
   localparam logic [7:0]   ADR_E1_ARB    = 8'hf4;
   localparam logic [7:0]   ADR_DEV_ID    = 8'hfe;
   localparam logic [7:0]   ADR_DEV_REV   = 8'hff;

   // Writable bits of each writable global register and of the two channel registers
   localparam logic [7:0]   MSK_CLK_DATA  = 8'hfb;
   localparam logic [7:0]   MSK_GAUGE     = 8'h37;
   localparam logic [7:0]   MSK_EQ_FLAG   = 8'h7f;
   localparam logic [7:0]   MSK_SLICER    = 8'h0f;
   localparam logic [7:0]   MSK_MCLK_OUT  = 8'hf0;
   localparam logic [7:0]   MSK_ERR_SEL   = 8'hcf;
   localparam logic [7:0]   MSK_CNT_UPD   = 8'h1f;
   localparam logic [7:0]   MSK_CLK_SRC   = 8'h3f;
   localparam logic [7:0]   MSK_E1_ARB    = 8'h01;
   localparam logic [7:0]   MSK_CHAN_REG0 = 8'hbf;
   localparam logic [7:0]   MSK_CHAN_REG1 = 8'hff;

   // Values after reset
   localparam logic [7:0]   RST_BYTE      = 8'h00;

   // Channel register field positions
   localparam int           POS_PRBS      = 7;
   localparam int           POS_RX_ON     = 5;
   localparam int           POS_RX_TERM   = 7;
   localparam int           POS_TX_TERM   = 6;
   localparam int           POS_IMP       = 4;
   localparam int           POS_RX_JA     = 3;
   localparam int           POS_TX_JA     = 2;

   // Equalizer code boundaries
   localparam logic [4:0]   EQ_T1S_LO     = 5'h08;
   localparam logic [4:0]   EQ_T1S_ARB    = 5'h0d;
   localparam logic [4:0]   EQ_T1G_LO     = 5'h0e;
   localparam logic [4:0]   EQ_T1G_ARB    = 5'h13;
   localparam logic [4:0]   EQ_E1S_COAX   = 5'h1c;
   localparam logic [4:0]   EQ_E1S_TP     = 5'h1d;
   localparam logic [4:0]   EQ_E1G_COAX   = 5'h1e;
   localparam logic [4:0]   EQ_E1G_TP     = 5'h1f;

   typedef enum logic [2:0] {
      LM_NONE, LM_T1_SHORT, LM_T1_GAIN, LM_E1_SHORT, LM_E1_GAIN
   } lcr_line_mode_t;

   // Decoded equalizer setting of one channel
   typedef struct packed {
      lcr_line_mode_t mode;
      logic [2:0]     lbo_range;
      logic           arb_pulse;
      logic           hdb3_coding;
      logic           coax_75;
   } lcr_eq_t;

   // Per-channel configuration seen by the line front end
   typedef struct packed {
      logic       prbs_select;
      logic       receiver_power_on;
      logic [4:0] equalizer_code;
      lcr_eq_t    eq;
      logic       rx_termination_select;
      logic       tx_termination_select;
      logic [1:0] line_impedance_select;
      logic       rx_jitter_atten_enable;
      logic       tx_jitter_atten_enable;
   } lcr_chan_cfg_t;

   // Global settings shared by all channels
   typedef struct packed {
      logic [7:0] clock_data_ctrl;
      logic [7:0] rx_gauge_ctrl;
      logic [7:0] eq_flag_threshold;
      logic [7:0] slicer_eq_gain;
      logic [7:0] master_clock_out_sel;
      logic [7:0] error_counter_chan_sel;
      logic [7:0] counter_update_reset;
      logic [7:0] clock_source_select;
      logic       e1_arbitrary_pulse_enable;
   } lcr_glob_cfg_t;

   // Equalizer code to line mode, build-out range and coding
   function automatic lcr_eq_t lcr_eq_decode(input logic [4:0] code);
      lcr_eq_t e;
      e = '0;
      if (code >= EQ_T1S_LO && code <= EQ_T1S_ARB) begin
         e.mode        = LM_T1_SHORT;
         e.lbo_range   = 3'(code - EQ_T1S_LO);
         e.arb_pulse   = (code == EQ_T1S_ARB);
      end else if (code >= EQ_T1G_LO && code <= EQ_T1G_ARB) begin
         e.mode        = LM_T1_GAIN;
         e.lbo_range   = 3'(code - EQ_T1G_LO);
         e.arb_pulse   = (code == EQ_T1G_ARB);
      end else if (code >= EQ_E1S_COAX) begin
         e.mode        = (code <= EQ_E1S_TP) ? LM_E1_SHORT : LM_E1_GAIN;
         e.hdb3_coding = 1'b1;
         e.coax_75     = (code == EQ_E1S_COAX) || (code == EQ_E1G_COAX);
      end
      return e;
   endfunction : lcr_eq_decode

endpackage : lcr_pkg

// *** rtl/lcr_bus.sv ***
`timescale 1ns/10ps
`default_nettype none

// Strobe handshake: one access per strobe, acknowledged until release
module lcr_bus (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Host strobes, active low
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   // Access pulses towards the register file
   output logic            rd_p,
   output logic            wr_p,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            ack,
   output logic            busy
);

   typedef struct packed {
      logic       busy;
      logic       rd_p;
      logic       wr_p;
      logic       ack;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lcr_bus_st_t;

   lcr_bus_st_t s_q;
   lcr_bus_st_t s_d;
   logic        strobe;

   assign strobe = !cs_n && (!rd_n || !wr_n);

   // Pulses last one cycle; a held strobe never repeats an access
   always_comb begin
      s_d      = s_q;
      s_d.rd_p = 1'b0;
      s_d.wr_p = 1'b0;
      if (!s_q.busy && strobe) begin
         s_d.busy  = 1'b1;
         s_d.rd_p  = !rd_n;
         s_d.wr_p  = rd_n;
         s_d.addr  = addr;
         s_d.wdata = wdata;
      end else if (s_q.busy && strobe) begin
         s_d.ack = 1'b1;
      end else if (!strobe) begin
         s_d.busy = 1'b0;
         s_d.ack  = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_p    = s_q.rd_p;
   assign wr_p    = s_q.wr_p;
   assign addr_o  = s_q.addr;
   assign wdata_o = s_q.wdata;
   assign ack     = s_q.ack;
   assign busy    = s_q.busy;

endmodule : lcr_bus

`default_nettype wire

// *** rtl/lcr_chan.sv ***
`timescale 1ns/10ps
`default_nettype none

// One channel's pattern/equalizer and termination/jitter registers
module lcr_chan (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Write port
   input  wire logic                   wr0,
   input  wire logic                   wr1,
   input  wire logic [7:0]             wdata,
   // Global receiver enable pin
   input  wire logic                   rx_enable,
   // Register contents and decoded setting
   output logic [7:0]                  reg0,
   output logic [7:0]                  reg1,
   output lcr_pkg::lcr_chan_cfg_t      cfg
);

   typedef struct packed {
      logic [7:0]             reg0;
      logic [7:0]             reg1;
      lcr_pkg::lcr_chan_cfg_t cfg;
   } lcr_chan_st_t;

   lcr_chan_st_t s_q;
   lcr_chan_st_t s_d;

   // Writes land first, the decoded setting follows one cycle later
   always_comb begin
      s_d = s_q;
      if (wr0) begin
         s_d.reg0 = wdata & lcr_pkg::MSK_CHAN_REG0;
      end
      if (wr1) begin
         s_d.reg1 = wdata & lcr_pkg::MSK_CHAN_REG1;
      end
      s_d.cfg.prbs_select            = s_q.reg0[lcr_pkg::POS_PRBS];
      s_d.cfg.receiver_power_on      =
         s_q.reg0[lcr_pkg::POS_RX_ON] && rx_enable;
      s_d.cfg.equalizer_code         = s_q.reg0[4:0];
      s_d.cfg.eq                     = lcr_pkg::lcr_eq_decode(s_q.reg0[4:0]);
      s_d.cfg.rx_termination_select  = s_q.reg1[lcr_pkg::POS_RX_TERM];
      s_d.cfg.tx_termination_select  = s_q.reg1[lcr_pkg::POS_TX_TERM];
      s_d.cfg.line_impedance_select  =
         s_q.reg1[lcr_pkg::POS_IMP +: 2];
      s_d.cfg.rx_jitter_atten_enable = s_q.reg1[lcr_pkg::POS_RX_JA];
      s_d.cfg.tx_jitter_atten_enable = s_q.reg1[lcr_pkg::POS_TX_JA];
   end

   // Everything comes up zero: receiver off, high impedance, JA bypassed
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q     <= '0;
         s_q.reg0 <= lcr_pkg::RST_BYTE;
         s_q.reg1 <= lcr_pkg::RST_BYTE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg0 = s_q.reg0;
   assign reg1 = s_q.reg1;
   assign cfg  = s_q.cfg;

endmodule : lcr_chan

`default_nettype wire

// *** rtl/lcr_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

module lcr_regs #(
   parameter logic [7:0] DEVICE_ID  = 8'h5a,   // Arbitrary value
   parameter logic [7:0] DEVICE_REV = 8'h01    // Arbitrary value
) (
   // Clock and reset
   input  wire logic                              CLOCK,
   input  wire logic                              RST,
   // Parallel host bus
   input  wire logic                              CS_N,
   input  wire logic                              RD_N,
   input  wire logic                              WR_N,
   input  wire logic [7:0]                        ADDR,
   input  wire logic [7:0]                        DATA_IN,
   output logic      [7:0]                        DATA_OUT,
   output logic                                   DATA_OE,
   output logic                                   RDY_N,
   // Device pins and state from the line side
   input  wire logic                              RX_ENABLE,
   input  wire logic [7:0]                        ERROR_COUNT,
   input  wire logic [lcr_pkg::NUM_CHAN-1:0]      CHAN_EVENT,
   // Configuration towards the line side
   output lcr_pkg::lcr_chan_cfg_t [lcr_pkg::NUM_CHAN-1:0] CHAN_CFG,
   output lcr_pkg::lcr_glob_cfg_t                 GLOB_CFG,
   output logic [lcr_pkg::NUM_CHAN-1:0]           CHAN_IRQ
);

   ////////////////////////////////////////////////////////////////////
   // Bus front end

   logic       rd_p;
   logic       wr_p;
   logic [7:0] a;
   logic [7:0] wd;
   logic       busy;

   lcr_bus u_bus (
      .clk     (CLOCK),
      .rst     (RST),
      .cs_n    (CS_N),
      .rd_n    (RD_N),
      .wr_n    (WR_N),
      .addr    (ADDR),
      .wdata   (DATA_IN),
      .rd_p    (rd_p),
      .wr_p    (wr_p),
      .addr_o  (a),
      .wdata_o (wd),
      .ack     (),
      .busy    (busy)
   );

   ////////////////////////////////////////////////////////////////////
   // Address decode

   // Channel block hit: upper nibble names the channel
   function automatic logic chan_hit(input logic [7:0] ad,
                                     input logic [3:0] ch,
                                     input logic [3:0] rg);
      return (ad[7:4] == ch) && (ad[3:0] == rg);
   endfunction : chan_hit

   logic [lcr_pkg::NUM_CHAN-1:0] ch_wr0;
   logic [lcr_pkg::NUM_CHAN-1:0] ch_wr1;
   logic [7:0]                   ch_reg0 [lcr_pkg::NUM_CHAN];
   logic [7:0]                   ch_reg1 [lcr_pkg::NUM_CHAN];

   ////////////////////////////////////////////////////////////////////
   // Channel register blocks

   for (genvar g = 0; g < lcr_pkg::NUM_CHAN; g++) begin : g_chan
      localparam logic [3:0] CH = 4'(g);
      // Block of channel g sits at g times 16
      assign ch_wr0[g] = wr_p && chan_hit(a, CH, lcr_pkg::CHAN_REG0);
      assign ch_wr1[g] = wr_p && chan_hit(a, CH, lcr_pkg::CHAN_REG1);

      lcr_chan u_chan (
         .clk       (CLOCK),
         .rst       (RST),
         .wr0       (ch_wr0[g]),
         .wr1       (ch_wr1[g]),
         .wdata     (wd),
         .rx_enable (RX_ENABLE),
         .reg0      (ch_reg0[g]),
         .reg1      (ch_reg1[g]),
         .cfg       (CHAN_CFG[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Global registers and read path

   typedef struct packed {
      lcr_pkg::lcr_glob_cfg_t       glob;
      logic [lcr_pkg::NUM_CHAN-1:0] irq;
      logic [7:0]                   rdata;
      logic                         oe;
      logic                         rdy_n;
   } lcr_top_st_t;

   lcr_top_st_t s_q;
   lcr_top_st_t s_d;
   logic [7:0]  rmux;
   logic [7:0]  ch_rd;

   // Channel read: only the first two registers hold state here
   always_comb begin
      ch_rd = 8'h00;
      if (a[7:4] <= lcr_pkg::CHAN_LAST) begin
         if (a[3:0] == lcr_pkg::CHAN_REG0) begin
            ch_rd = ch_reg0[a[7:4]];
         end else if (a[3:0] == lcr_pkg::CHAN_REG1) begin
            ch_rd = ch_reg1[a[7:4]];
         end
      end
   end

   // Read multiplexer; unmapped and test space reads as zero
   always_comb begin
      rmux = 8'h00;
      unique case (a)
         lcr_pkg::ADR_CLK_DATA: rmux = s_q.glob.clock_data_ctrl;
         lcr_pkg::ADR_GAUGE:    rmux = s_q.glob.rx_gauge_ctrl;
         lcr_pkg::ADR_EQ_FLAG:  rmux = s_q.glob.eq_flag_threshold;
         lcr_pkg::ADR_SLICER:   rmux = s_q.glob.slicer_eq_gain;
         lcr_pkg::ADR_MCLK_OUT: rmux = s_q.glob.master_clock_out_sel;
         lcr_pkg::ADR_ERR_SEL:  rmux = s_q.glob.error_counter_chan_sel;
         lcr_pkg::ADR_CNT_UPD:  rmux = s_q.glob.counter_update_reset;
         lcr_pkg::ADR_SPARE:    rmux = 8'h00;
         lcr_pkg::ADR_ERR_CNT:  rmux = ERROR_COUNT;
         lcr_pkg::ADR_CLK_SRC:  rmux = s_q.glob.clock_source_select;
         lcr_pkg::ADR_IRQ_LO:   rmux = s_q.irq[7:0];
         lcr_pkg::ADR_IRQ_HI:   rmux = {2'b00, s_q.irq[13:8]};
         lcr_pkg::ADR_E1_ARB:
            rmux = {7'h00, s_q.glob.e1_arbitrary_pulse_enable};
         lcr_pkg::ADR_DEV_ID:   rmux = DEVICE_ID;
         lcr_pkg::ADR_DEV_REV:  rmux = DEVICE_REV;
         default:               rmux = ch_rd;
      endcase
   end

   // Global writes are masked so reserved bits stay zero
   always_comb begin
      s_d = s_q;
      if (wr_p) begin
         unique case (a)
            lcr_pkg::ADR_CLK_DATA:
               s_d.glob.clock_data_ctrl = wd & lcr_pkg::MSK_CLK_DATA;
            lcr_pkg::ADR_GAUGE:
               s_d.glob.rx_gauge_ctrl = wd & lcr_pkg::MSK_GAUGE;
            lcr_pkg::ADR_EQ_FLAG:
               s_d.glob.eq_flag_threshold = wd & lcr_pkg::MSK_EQ_FLAG;
            lcr_pkg::ADR_SLICER:
               s_d.glob.slicer_eq_gain = wd & lcr_pkg::MSK_SLICER;
            lcr_pkg::ADR_MCLK_OUT:
               s_d.glob.master_clock_out_sel = wd & lcr_pkg::MSK_MCLK_OUT;
            lcr_pkg::ADR_ERR_SEL:
               s_d.glob.error_counter_chan_sel = wd & lcr_pkg::MSK_ERR_SEL;
            lcr_pkg::ADR_CNT_UPD:
               s_d.glob.counter_update_reset = wd & lcr_pkg::MSK_CNT_UPD;
            lcr_pkg::ADR_CLK_SRC:
               s_d.glob.clock_source_select = wd & lcr_pkg::MSK_CLK_SRC;
            lcr_pkg::ADR_E1_ARB:
               s_d.glob.e1_arbitrary_pulse_enable = wd[0];
            default: ;
         endcase
      end

      // Reading a status byte clears it; a new event the same cycle wins
      if (rd_p && a == lcr_pkg::ADR_IRQ_LO) begin
         s_d.irq[7:0] = 8'h00;
      end
      if (rd_p && a == lcr_pkg::ADR_IRQ_HI) begin
         s_d.irq[13:8] = 6'h00;
      end
      s_d.irq = s_d.irq | CHAN_EVENT;

      // Read data captured once, held with the acknowledge
      if (rd_p) begin
         s_d.rdata = rmux;
         s_d.oe    = 1'b1;
      end else if (!busy) begin
         s_d.oe    = 1'b0;
      end
      s_d.rdy_n = !(busy && !rd_p && !wr_p);
   end

   // State register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         s_q       <= '0;
         s_q.rdy_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   assign DATA_OUT = s_q.rdata;
   assign DATA_OE  = s_q.oe;
   assign RDY_N    = s_q.rdy_n;
   assign GLOB_CFG = s_q.glob;
   assign CHAN_IRQ = s_q.irq;

endmodule : lcr_regs

`default_nettype wire

// *** verification/lcr_regs_props.sv ***
`timescale 1ns/10ps
`default_nettype none

// Handshake and decode relations seen at the register block's pins
module lcr_regs_props (
   // Clock and reset
   input wire logic                                   CLOCK,
   input wire logic                                   RST,
   // Host bus
   input wire logic                                   CS_N,
   input wire logic                                   RD_N,
   input wire logic                                   WR_N,
   input wire logic                                   DATA_OE,
   input wire logic                                   RDY_N,
   // Line side
   input wire logic                                   RX_ENABLE,
   input wire logic [lcr_pkg::NUM_CHAN-1:0]           CHAN_EVENT,
   input wire lcr_pkg::lcr_chan_cfg_t [lcr_pkg::NUM_CHAN-1:0] CHAN_CFG,
   input wire logic [lcr_pkg::NUM_CHAN-1:0]           CHAN_IRQ
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   logic                          act;
   logic [lcr_pkg::NUM_CHAN-1:0]  pw;
   lcr_pkg::lcr_chan_cfg_t        c0;

   // Strobe activity, power bits gathered, channel 0 alias
   assign act = !CS_N && (!RD_N || !WR_N);
   assign c0  = CHAN_CFG[0];
   always_comb begin
      for (int i = 0; i < lcr_pkg::NUM_CHAN; i++) begin
         pw[i] = CHAN_CFG[i].receiver_power_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // An access is taken on the first active edge after an idle one
   sequence s_rd_start; act && !RD_N && !$past(act); endsequence
   sequence s_wr_start; act && RD_N && !$past(act); endsequence
   sequence s_ack; RDY_N [*3] ##1 !RDY_N; endsequence

   property p_rd_answer; s_rd_start |-> ##2 DATA_OE ##1 !RDY_N; endproperty
   property p_wr_answer; s_wr_start |-> (!DATA_OE throughout s_ack); endproperty
   property p_rd_ack; s_rd_start |-> s_ack; endproperty
   property p_ack_stands; act && !RDY_N |=> !RDY_N && DATA_OE == $past(DATA_OE); endproperty
   // The acknowledge lags the release by one edge, so it clears on the second edge
   property p_ack_ends; !act && !RDY_N |=> ##1 RDY_N && !DATA_OE; endproperty
   property p_rx_gate; !$past(RX_ENABLE) |-> pw == '0; endproperty
   property p_irq_set;
      |CHAN_EVENT |=> (CHAN_IRQ & $past(CHAN_EVENT)) == $past(CHAN_EVENT);
   endproperty
   // Only a read may clear; a read strobe absent for two edges keeps every bit
   property p_irq_hold;
      RD_N && $past(RD_N) |=> (CHAN_IRQ & $past(CHAN_IRQ)) == $past(CHAN_IRQ);
   endproperty
   property p_eq_arb;
      c0.eq.arb_pulse == (c0.equalizer_code == 5'h0d || c0.equalizer_code == 5'h13);
   endproperty
   property p_eq_e1;
      c0.equalizer_code >= 5'h1c |-> c0.eq.hdb3_coding && c0.eq.coax_75 == !c0.equalizer_code[0]
         && c0.eq.mode == (c0.equalizer_code[1] ? lcr_pkg::LM_E1_GAIN : lcr_pkg::LM_E1_SHORT);
   endproperty

   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_wr_answer: assert property (p_wr_answer) else $error("write ack wrong");
   a_rd_ack: assert property (p_rd_ack) else $error("read ack timing wrong");
   a_ack_stands: assert property (p_ack_stands) else $error("ack dropped early");
   a_ack_ends: assert property (p_ack_ends) else $error("ack held after release");
   a_rx_gate: assert property (p_rx_gate) else $error("receiver on with pin low");
   a_irq_set: assert property (p_irq_set) else $error("event not latched");
   a_irq_hold: assert property (p_irq_hold) else $error("status lost without read");
   a_eq_arb: assert property (p_eq_arb) else $error("arbitrary pulse decode");
   a_eq_e1: assert property (p_eq_e1) else $error("E1 code decode wrong");
endmodule : lcr_regs_props

bind lcr_regs lcr_regs_props lcr_regs_props_i (
   .CLOCK(CLOCK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_OE(DATA_OE),
   .RDY_N(RDY_N), .RX_ENABLE(RX_ENABLE), .CHAN_EVENT(CHAN_EVENT), .CHAN_CFG(CHAN_CFG),
   .CHAN_IRQ(CHAN_IRQ)
);

`default_nettype wire

// *** verification/lcr_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// Host processor on the strobe bus; one byte per access
module lcr_host (
   // Clock
   input  wire logic       clk,
   // Bus towards the device
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic [7:0]      addr,
   output logic [7:0]      data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   input  wire logic       rdy_n,
   // Set when an access never got its acknowledge
   output logic            hung
);
   logic       drv_q;
   logic [7:0] wd_q;

   // Shared wire: undriven it shows the inverse of the last byte, never a stale copy
   assign data_in = data_oe ? data_out : (drv_q ? wd_q : ~wd_q);

   initial begin
      cs_n  = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
      addr  = 8'h00;
      drv_q = 1'b0;
      wd_q  = 8'h00;
      hung  = 1'b0;
   end

   // Strobe held until acknowledge is sampled, then released and one idle edge left
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      @(negedge clk);
      addr  = a;
      wd_q  = d;
      drv_q = wr;
      cs_n  = 1'b0;
      rd_n  = wr;
      wr_n  = !wr;
      n     = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy_n !== 1'b0 && n < 20);
      if (rdy_n !== 1'b0) hung = 1'b1;
      q = data_in;
      @(negedge clk);
      cs_n  = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
      drv_q = 1'b0;
      @(negedge clk);
   endtask : xfer
endmodule : lcr_host

`default_nettype wire

// *** verification/lcr_regs_test.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module lcr_regs_test;
   logic                                  CLOCK, RST, CS_N, RD_N, WR_N, DATA_OE, RDY_N;
   logic                                  RX_ENABLE, hung;
   logic [7:0]                            ADDR, DATA_IN, DATA_OUT, ERROR_COUNT, q;
   logic [lcr_pkg::NUM_CHAN-1:0]          CHAN_EVENT, CHAN_IRQ;
   lcr_pkg::lcr_chan_cfg_t [lcr_pkg::NUM_CHAN-1:0] CHAN_CFG;
   lcr_pkg::lcr_glob_cfg_t                GLOB_CFG;
   lcr_pkg::lcr_eq_t                      e;
   int                                    cycles, miscompares, checks_done;
   logic [7:0]                            pat [4] = '{8'hb4, 8'h4b, 8'h68, 8'h1c};
   logic [7:0]                            ra [12] = '{8'hd2, 8'he7, 8'he3, 8'hec, 8'hf4, 8'he0,
      8'he1, 8'he2, 8'he4, 8'he5, 8'he6, 8'he9};
   logic [7:0]                            rx [12] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h01, 8'hfb,
      8'h37, 8'h7f, 8'hf0, 8'hcf, 8'h1f, 8'h3f};

   // Identity values are arbitrary
   lcr_regs #(.DEVICE_ID(8'h3c), .DEVICE_REV(8'h07)) lcr_regs_i (
      .CLOCK(CLOCK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR),
      .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .RDY_N(RDY_N),
      .RX_ENABLE(RX_ENABLE), .ERROR_COUNT(ERROR_COUNT), .CHAN_EVENT(CHAN_EVENT),
      .CHAN_CFG(CHAN_CFG), .GLOB_CFG(GLOB_CFG), .CHAN_IRQ(CHAN_IRQ));
   lcr_host lcr_host_i (
      .clk(CLOCK), .cs_n(CS_N), .rd_n(RD_N), .wr_n(WR_N), .addr(ADDR), .data_in(DATA_IN),
      .data_out(DATA_OUT), .data_oe(DATA_OE), .rdy_n(RDY_N), .hung(hung));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] s;
      lcr_host_i.xfer(1'b1, a, d, s);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      lcr_host_i.xfer(1'b0, a, 8'h00, d);
   endtask : rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // Clock, and a ceiling far above the few hundred cycles the run needs
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 5000 || hung === 1'b1) begin
         miscompares++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      RX_ENABLE = 1'b1;
      ERROR_COUNT = 8'ha5;
      CHAN_EVENT = '0;
      RST = 1'b1;
      repeat (4) @(negedge CLOCK);
      RST = 1'b0;
      // Values after reset
      rd(8'h00, q); `CHK("reg0 reset", 8'h00, q);
      rd(8'h01, q); `CHK("reg1 reset", 8'h00, q);
      `CHK("power reset", 1'b0, CHAN_CFG[0].receiver_power_on);
      // All ones into register 0: the unused bit stays clear
      wr(8'h00, 8'hff);
      rd(8'h00, q); `CHK("reg0 rb", 8'hbf, q);
      `CHK("prbs", 1'b1, CHAN_CFG[0].prbs_select);
      `CHK("power on", 1'b1, CHAN_CFG[0].receiver_power_on);
      RX_ENABLE = 1'b0;
      repeat (2) @(negedge CLOCK);
      `CHK("power gated", 1'b0, CHAN_CFG[0].receiver_power_on);
      RX_ENABLE = 1'b1;
      wr(8'h00, 8'h20);
      `CHK("qrss", 1'b0, CHAN_CFG[0].prbs_select);
      `CHK("power back", 1'b1, CHAN_CFG[0].receiver_power_on);
      // Termination, impedance and jitter bits, every impedance code once
      for (int i = 0; i < 4; i++) begin
         wr(8'h01, pat[i]);
         rd(8'h01, q); `CHK("reg1 rb", pat[i], q);
         `CHK("reg1 fields", pat[i][7:2], {CHAN_CFG[0].rx_termination_select, CHAN_CFG[0].tx_termination_select, CHAN_CFG[0].line_impedance_select, CHAN_CFG[0].rx_jitter_atten_enable, CHAN_CFG[0].tx_jitter_atten_enable});
      end
      // Every equalizer code against the decode table
      for (int i = 0; i < 32; i++) begin
         e = '0;
         if (i >= 8 && i <= 13) begin
            e.mode = lcr_pkg::LM_T1_SHORT;
            e.lbo_range = 3'(i - 8);
         end else if (i >= 14 && i <= 19) begin
            e.mode = lcr_pkg::LM_T1_GAIN;
            e.lbo_range = 3'(i - 14);
         end else if (i >= 28) begin
            e.mode = (i <= 29) ? lcr_pkg::LM_E1_SHORT : lcr_pkg::LM_E1_GAIN;
         end
         e.arb_pulse = (i == 13 || i == 19);
         e.hdb3_coding = (i >= 28);
         e.coax_75 = (i == 28 || i == 30);
         wr(8'h00, {3'b001, 5'(i)});
         `CHK("eq", e, CHAN_CFG[0].eq);
      end
      // Last channel's block, channels 0 and 1 untouched
      wr(8'hd0, 8'h9c);
      `CHK("ch13 code", 5'h1c, CHAN_CFG[13].equalizer_code);
      `CHK("ch13 prbs", 1'b1, CHAN_CFG[13].prbs_select);
      `CHK("ch0 kept", 5'h1f, CHAN_CFG[0].equalizer_code);
      rd(8'h10, q); `CHK("ch1 untouched", 8'h00, q);
      // Reserved places and masked global bits
      for (int i = 0; i < 12; i++) begin
         wr(ra[i], 8'hff);
         rd(ra[i], q); `CHK("masked rb", rx[i], q);
      end
      `CHK("slicer", 8'h0f, GLOB_CFG.slicer_eq_gain);
      `CHK("e1 arb", 1'b1, GLOB_CFG.e1_arbitrary_pulse_enable);
      // Read-only places
      rd(8'he8, q); `CHK("err count", 8'ha5, q);
      wr(8'hfe, 8'h00);
      rd(8'hfe, q); `CHK("dev id", 8'h3c, q);
      rd(8'hff, q); `CHK("dev rev", 8'h07, q);
      // Sticky status, cleared by reading each half
      CHAN_EVENT = 14'h0204;
      @(negedge CLOCK);
      CHAN_EVENT = '0;
      @(negedge CLOCK);
      `CHK("irq set", 14'h0204, CHAN_IRQ);
      rd(8'hea, q); `CHK("irq lo", 8'h04, q);
      `CHK("irq lo clr", 14'h0200, CHAN_IRQ);
      rd(8'heb, q); `CHK("irq hi", 8'h02, q);
      `CHK("irq hi clr", 14'h0000, CHAN_IRQ);
      stop_test();
   end
endmodule : lcr_regs_test

`default_nettype wire
